// File: inc/sqm_map.vh
// Purpose: constants for the slicer error quality monitor
// Assumes: AXI4-Lite word registers, byte addresses below
// Notes:   included by every design file of the monitor
`ifndef SQM_MAP_VH
`define SQM_MAP_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SQM_OFF_PAGE     4'h0
`define SQM_OFF_CFG      4'h4
`define SQM_OFF_RESULT   4'h8
`define SQM_OFF_STATUS   4'hC
`define SQM_MON_PAGE     5'h01

// ----------------------------------------------------------------
// configuration fields
// ----------------------------------------------------------------
`define SQM_CFG_EN_BIT   0
`define SQM_CFG_SQ_BIT   1
`define SQM_CFG_KP_LSB   4
`define SQM_CFG_KP_MSB   7
`define SQM_CFG_PR_LSB   8
`define SQM_CFG_PR_MSB   9
`define SQM_CFG_CAP_BIT  15
`define SQM_RST_KP       4'h6
`define SQM_RST_PAGE     5'h00

// ----------------------------------------------------------------
// ideal levels, thresholds and error bounds
// ----------------------------------------------------------------
`define SQM_LVL_HI       10'sh080
`define SQM_LVL_MID      10'sh040
`define SQM_THR_G_HI     10'sh060
`define SQM_THR_G_LO     10'sh020
`define SQM_THR_F        10'sh040
`define SQM_LIM_G        10'sh020
`define SQM_LIM_F        10'sh040

// ----------------------------------------------------------------
// timing: update interval in symbols
// ----------------------------------------------------------------
`define SQM_UPD_MS       1
`define SQM_SYMS_PER_MS  125000

// ----------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------
`define SQM_RESP_OKAY    2'h0
`define SQM_RESP_SLVERR  2'h2

`endif

// File: hw/sqm_filter.v
// Purpose: one pair's error processing, low-pass filter and held result
// Assumes: err is the bounded signed slicer error of this pair
// Notes:   state carries eight fraction bits so small gains still move it
`timescale 1ns/10ps
`include "sqm_map.vh"

module sqm_filter (
    // clock and reset
    input  wire        mclk,
    input  wire        rst_sync_n,
    // sample side
    input  wire        samp_vld,
    input  wire [7:0]  err,
    input  wire        gig,
    // control
    input  wire        enable,
    input  wire        square,
    input  wire [3:0]  kp,
    input  wire        upd_tick,
    // result
    output reg  [15:0] held_q
);

    reg  [22:0]        state_q;
    wire [7:0]         neg;
    wire [6:0]         mag;
    wire [7:0]         scaled;
    wire [15:0]        sq;
    wire [14:0]        proc;
    wire signed [23:0] diff;
    wire signed [23:0] step;

    assign neg    = (~err) + 8'h01;
    assign mag    = err[7] ? neg[6:0] : err[6:0];
    assign scaled = gig ? {mag, 1'b0} : {1'b0, mag};
    assign sq     = scaled * scaled;
    assign proc   = square ? sq[14:0] : {7'h00, scaled};
    assign diff   = $signed({1'b0, proc, 8'h00}) - $signed({1'b0, state_q});
    assign step   = diff >>> kp;

    always @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state_q <= 23'h000000;
            held_q  <= 16'h0000;
        end else begin
            if (samp_vld && enable) begin
                state_q <= state_q + step[22:0];
            end
            if (upd_tick) begin
                held_q <= {1'b0, state_q[22:8]};
            end
        end
    end

endmodule

// File: hw/sqm_top.v
// Purpose: per-port receive signal quality monitor with AXI4-Lite registers
// Assumes: samples arrive on mclk with a one-cycle valid, one per symbol
// Notes:   four pairs filtered in parallel; result reads are a held snapshot
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`include "sqm_map.vh"

module sqm_top #(
    parameter [16:0] SYMS_PER_MS = `SQM_SYMS_PER_MS
) (
    // clock and reset
    input  wire        mclk,
    input  wire        rstn,
    // receive slicer side
    input  wire        samp_vld,
    input  wire        speed_gig,
    input  wire [8:0]  samp_pair0,
    input  wire [8:0]  samp_pair1,
    input  wire [8:0]  samp_pair2,
    input  wire [8:0]  samp_pair3,
    // axi4-lite write address
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [3:0]  s_axi_awaddr,
    // axi4-lite write data
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    // axi4-lite write response
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    output wire [1:0]  s_axi_bresp,
    // axi4-lite read address
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    input  wire [3:0]  s_axi_araddr,
    // axi4-lite read data
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp
);

    // ----------------------------------------------------------------
    // register selects, one-hot
    // ----------------------------------------------------------------
    localparam [4:0] SEL_PAGE   = 5'h01;
    localparam [4:0] SEL_CFG    = 5'h02;
    localparam [4:0] SEL_RESULT = 5'h04;
    localparam [4:0] SEL_STATUS = 5'h08;
    localparam [4:0] SEL_NONE   = 5'h10;

    // ----------------------------------------------------------------
    // decode and slicing functions
    // ----------------------------------------------------------------
    function [4:0] reg_sel;
        input [3:0] addr;
        begin
            case (addr)
                `SQM_OFF_PAGE:   reg_sel = SEL_PAGE;
                `SQM_OFF_CFG:    reg_sel = SEL_CFG;
                `SQM_OFF_RESULT: reg_sel = SEL_RESULT;
                `SQM_OFF_STATUS: reg_sel = SEL_STATUS;
                default:         reg_sel = SEL_NONE;
            endcase
        end
    endfunction

    // nearest ideal level by threshold, then bounded error
    function [7:0] slice_err;
        input [8:0] s;
        input       gig;
        reg signed [9:0] v;
        reg signed [9:0] lvl;
        reg signed [9:0] e;
        reg signed [9:0] lim;
        begin
            v   = {s[8], s};
            lvl = 10'sh000;
            if (gig) begin
                lim = `SQM_LIM_G;
                if (v >= `SQM_THR_G_HI) begin
                    lvl = `SQM_LVL_HI;
                end else if (v >= `SQM_THR_G_LO) begin
                    lvl = `SQM_LVL_MID;
                end else if (v > -`SQM_THR_G_LO) begin
                    lvl = 10'sh000;
                end else if (v > -`SQM_THR_G_HI) begin
                    lvl = -`SQM_LVL_MID;
                end else begin
                    lvl = -`SQM_LVL_HI;
                end
            end else begin
                lim = `SQM_LIM_F;
                if (v >= `SQM_THR_F) begin
                    lvl = `SQM_LVL_HI;
                end else if (v > -`SQM_THR_F) begin
                    lvl = 10'sh000;
                end else begin
                    lvl = -`SQM_LVL_HI;
                end
            end
            e = v - lvl;
            // samples beyond the outer levels would overrun the bound
            if (e > lim) begin
                e = lim;
            end else if (e < -lim) begin
                e = -lim;
            end
            slice_err = e[7:0];
        end
    endfunction

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    reg rst_q1;
    reg rst_q2;
    wire rst_sync_n;

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_q1 <= 1'b0;
            rst_q2 <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_q2 <= rst_q1;
        end
    end
    assign rst_sync_n = rst_q2;

    // ----------------------------------------------------------------
    // control state
    // ----------------------------------------------------------------
    reg  [4:0]  page_q;
    reg         en_q;
    reg         sq_q;
    reg  [3:0]  kp_q;
    reg  [1:0]  pair_q;
    reg  [15:0] result_q;
    reg  [7:0]  upd_cnt_q;
    reg  [16:0] sym_cnt_q;
    reg         upd_tick_q;
    reg         vld_q;
    reg         gig_q;
    wire [31:0] err_bus;
    wire [63:0] held_bus;
    wire        on_page;

    assign on_page = (page_q == `SQM_MON_PAGE);

    // ----------------------------------------------------------------
    // slicer stage and per-pair filters
    // ----------------------------------------------------------------
    wire [35:0] samp_bus;
    assign samp_bus = {samp_pair3, samp_pair2, samp_pair1, samp_pair0};

    reg [31:0] err_q;
    always @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            err_q <= 32'h00000000;
            vld_q <= 1'b0;
            gig_q <= 1'b0;
        end else begin
            vld_q <= samp_vld;
            gig_q <= speed_gig;
            if (samp_vld) begin
                err_q <= err_bus;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : pair
            assign err_bus[8*g+7:8*g] = slice_err(samp_bus[9*g+8:9*g], speed_gig);
            sqm_filter u_filt (
                .mclk       (mclk),
                .rst_sync_n (rst_sync_n),
                .samp_vld   (vld_q),
                .err        (err_q[8*g+7:8*g]),
                .gig        (gig_q),
                .enable     (en_q),
                .square     (sq_q),
                .kp         (kp_q),
                .upd_tick   (upd_tick_q),
                .held_q     (held_bus[16*g+15:16*g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // millisecond update timer, counted in symbols
    // ----------------------------------------------------------------
    always @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sym_cnt_q  <= 17'h00000;
            upd_tick_q <= 1'b0;
            upd_cnt_q  <= 8'h00;
        end else begin
            upd_tick_q <= 1'b0;
            if (!en_q) begin
                sym_cnt_q <= 17'h00000;
            end else if (vld_q) begin
                if (sym_cnt_q == SYMS_PER_MS - 17'h00001) begin
                    sym_cnt_q  <= 17'h00000;
                    upd_tick_q <= 1'b1;
                    upd_cnt_q  <= upd_cnt_q + 8'h01;
                end else begin
                    sym_cnt_q <= sym_cnt_q + 17'h00001;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite write path
    // ----------------------------------------------------------------
    reg        aw_have_q;
    reg        w_have_q;
    reg [3:0]  awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0]  wstrb_q;
    reg        bvalid_q;
    reg [1:0]  bresp_q;
    wire       do_wr;
    wire [4:0] wsel;

    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready  = !w_have_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign do_wr         = aw_have_q && w_have_q && !bvalid_q;
    assign wsel          = reg_sel(awaddr_q);

    always @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= 4'h0;
            wdata_q   <= 32'h00000000;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `SQM_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_have_q) begin
                aw_have_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_have_q) begin
                w_have_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= (wsel == SEL_NONE) ? `SQM_RESP_SLVERR : `SQM_RESP_OKAY;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // configuration, page select and snapshot
    always @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            page_q   <= `SQM_RST_PAGE;
            en_q     <= 1'b0;
            sq_q     <= 1'b0;
            kp_q     <= `SQM_RST_KP;
            pair_q   <= 2'h0;
            result_q <= 16'h0000;
        end else if (do_wr) begin
            if (wsel == SEL_PAGE && wstrb_q[0]) begin
                page_q <= wdata_q[4:0];
            end
            // monitor registers ignore writes while another page is selected
            if (wsel == SEL_CFG && on_page) begin
                if (wstrb_q[0]) begin
                    en_q <= wdata_q[`SQM_CFG_EN_BIT];
                    sq_q <= wdata_q[`SQM_CFG_SQ_BIT];
                    kp_q <= wdata_q[`SQM_CFG_KP_MSB:`SQM_CFG_KP_LSB];
                end
                if (wstrb_q[1]) begin
                    pair_q <= wdata_q[`SQM_CFG_PR_MSB:`SQM_CFG_PR_LSB];
                    // pair taken from the same write as the capture bit
                    if (wdata_q[`SQM_CFG_CAP_BIT]) begin
                        result_q <= held_bus[16*wdata_q[9:8] +: 16];
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite read path
    // ----------------------------------------------------------------
    reg        rvalid_q;
    reg [31:0] rdata_q;
    reg [1:0]  rresp_q;
    reg [31:0] rd_mux;
    wire [4:0] rsel;

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign rsel          = reg_sel(s_axi_araddr);

    always @* begin
        rd_mux = 32'h00000000;
        case (rsel)
            SEL_PAGE: begin
                rd_mux = {27'h0000000, page_q};
            end
            SEL_CFG: begin
                // capture reads back as zero: it never holds a value
                if (on_page) begin
                    rd_mux = {22'h000000, pair_q, kp_q, 2'h0, sq_q, en_q};
                end
            end
            SEL_RESULT: begin
                if (on_page) begin
                    rd_mux = {16'h0000, result_q};
                end
            end
            SEL_STATUS: begin
                if (on_page) begin
                    rd_mux = {16'h0000, upd_cnt_q, 6'h00, en_q, gig_q};
                end
            end
            default: begin
                rd_mux = 32'h00000000;
            end
        endcase
    end

    always @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= `SQM_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && !rvalid_q) begin
                rvalid_q <= 1'b1;
                rdata_q  <= rd_mux;
                rresp_q  <= (rsel == SEL_NONE) ? `SQM_RESP_SLVERR : `SQM_RESP_OKAY;
            end else if (rvalid_q && s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

endmodule

// File: tb/sqm_checker.sv
// Purpose: bus and register checks on the monitor top ports
// Assumes: one read and one write in flight, word aligned map
// Notes:   bound to sqm_top after the module
`timescale 1ns/10ps
`include "sqm_map.vh"
module sqm_checker (
    // clock and reset
    input wire        mclk,
    input wire        rstn,
    // write side
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [3:0]  s_axi_awaddr,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [1:0]  s_axi_bresp,
    // read side
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [3:0]  s_axi_araddr,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp
);
    // addresses of the transfers in flight
    reg [3:0] ra_q;
    reg [3:0] wa_q;
    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ra_q <= 4'h0;
            wa_q <= 4'h0;
        end else begin
            if (s_axi_arvalid && s_axi_arready)
                ra_q <= s_axi_araddr;
            if (s_axi_awvalid && s_axi_awready)
                wa_q <= s_axi_awaddr;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence wr_answered;
        !s_axi_awready && !s_axi_wready ##[0:1] s_axi_bvalid;
    endsequence
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready) else $error("read not answered");
    rd_cause_a: assert property ($rose(s_axi_rvalid) |->
        $past(s_axi_arvalid) && $past(s_axi_arready)) else $error("read data unasked");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
        $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data moved");
    wr_answer_a: assert property (wr_taken |=> wr_answered)
        else $error("write not answered");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer moved");
    cap_clear_a: assert property (s_axi_rvalid && ra_q == `SQM_OFF_CFG |->
        !s_axi_rdata[`SQM_CFG_CAP_BIT]) else $error("capture bit stuck");
    res_width_a: assert property (s_axi_rvalid && ra_q == `SQM_OFF_RESULT |->
        s_axi_rdata[31:15] == 17'h00000) else $error("result too wide");
    rd_unmap_a: assert property (s_axi_rvalid && ra_q[1:0] != 2'h0 |->
        s_axi_rresp == `SQM_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad unmapped read");
    rd_map_a: assert property (s_axi_rvalid && ra_q[1:0] == 2'h0 |->
        s_axi_rresp == `SQM_RESP_OKAY) else $error("mapped read refused");
    wr_resp_a: assert property (s_axi_bvalid |-> s_axi_bresp ==
        (wa_q[1:0] == 2'h0 ? `SQM_RESP_OKAY : `SQM_RESP_SLVERR)) else $error("bad write code");
endmodule

// every checker port has a top port of the same name
bind sqm_top sqm_checker i_sqm_checker (.*);

// File: tb/sqm_slicer_model.sv
// Purpose: receive slicer stand-in driving equalised samples on four pairs
// Assumes: bench sets sample values, speed and spacing between strobes
// Notes:   between strobes the lines toggle, so no stale value can pass
`timescale 1ns/10ps
module sqm_slicer_model (
    // clock
    input  wire       mclk,
    // bench control
    input  wire [3:0] gap,
    input  wire       gig_in,
    input  wire [8:0] lvl0,
    input  wire [8:0] lvl1,
    input  wire [8:0] lvl2,
    input  wire [8:0] lvl3,
    // slicer outputs
    output reg        samp_vld,
    output reg        speed_gig,
    output reg  [8:0] samp_pair0,
    output reg  [8:0] samp_pair1,
    output reg  [8:0] samp_pair2,
    output reg  [8:0] samp_pair3
);
    reg [3:0] cnt_q;
    initial begin
        {samp_vld, speed_gig, cnt_q} = 6'h00;
        {samp_pair0, samp_pair1, samp_pair2, samp_pair3} = 36'h0;
    end
    // gap of zero gives a sample every cycle
    always @(posedge mclk) begin
        if (cnt_q >= gap) begin
            cnt_q      <= 4'h0;
            samp_vld   <= 1'b1;
            speed_gig  <= gig_in;
            samp_pair0 <= lvl0;
            samp_pair1 <= lvl1;
            samp_pair2 <= lvl2;
            samp_pair3 <= lvl3;
        end else begin
            cnt_q      <= cnt_q + 4'h1;
            samp_vld   <= 1'b0;
            samp_pair0 <= ~samp_pair0;
            samp_pair1 <= ~samp_pair1;
            samp_pair2 <= ~samp_pair2;
            samp_pair3 <= ~samp_pair3;
        end
    end
endmodule

// File: tb/test_sqm_top.sv
// Purpose: register level tests of the slicer error quality monitor
// Assumes: update interval shortened to 16 samples
// Notes:   rows: fast, gigabit, gigabit squared, fast squared
`timescale 1ns/10ps
`include "sqm_map.vh"
module test_sqm_top;
    localparam [16:0]  SYMS = 17'h00010;
    localparam [143:0] TS = {9'h00A, 9'h19C, 9'h08C, 9'h0C8, 9'h046, 9'h1D8, 9'h064, 9'h138,
                             9'h046, 9'h1D8, 9'h014, 9'h020, 9'h040, 9'h005, 9'h1C1, 9'h180};
    localparam [255:0] TE = {16'h000A, 16'h001C, 16'h000C, 16'h0040, 16'h000C, 16'h0030,
                             16'h0038, 16'h0040, 16'h0090, 16'h0900, 16'h0640, 16'h1000,
                             16'h1000, 16'h0019, 16'h0F81, 16'h0000};
    localparam [3:0]   TG = 4'h6;
    localparam [3:0]   TQ = 4'h3;
    reg         mclk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    reg         s_axi_rready, gig;
    reg  [3:0]  s_axi_awaddr, s_axi_araddr, gap;
    reg  [31:0] s_axi_wdata, cfgv, d;
    reg  [8:0]  lv [0:3];
    reg  [1:0]  r;
    integer     n_fail, comparisons, i, p;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire        samp_vld, speed_gig;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [8:0]  sp0, sp1, sp2, sp3;

    sqm_slicer_model i_sqm_slicer_model (.mclk(mclk), .gap(gap), .gig_in(gig),
        .lvl0(lv[0]), .lvl1(lv[1]), .lvl2(lv[2]), .lvl3(lv[3]), .samp_vld(samp_vld),
        .speed_gig(speed_gig), .samp_pair0(sp0), .samp_pair1(sp1), .samp_pair2(sp2),
        .samp_pair3(sp3));
    sqm_top #(.SYMS_PER_MS(SYMS)) i_sqm_top (.mclk(mclk), .rstn(rstn), .samp_vld(samp_vld),
        .speed_gig(speed_gig), .samp_pair0(sp0), .samp_pair1(sp1), .samp_pair2(sp2),
        .samp_pair3(sp3), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // ----------------------------------------------------------------
    // bus tasks
    // ----------------------------------------------------------------
    task check(input string what, input [31:0] seen, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("wrong value %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task summarize;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, n_fail);
            if (n_fail == 0 && comparisons > 0) begin
                $display("SIMULATION PASSED");
            end else begin
                $display("SIMULATION FAILED");
            end
            $finish;
        end
    endtask
    task tmo;
        begin
            n_fail = n_fail + 1;
            $display("wrong value bus wait expected answer seen none");
            summarize;
        end
    endtask
    // address and data offered together, each dropped once taken
    task wr(input [3:0] a, input [31:0] v, output [1:0] resp);
        integer k;
        reg     got;
        begin
            got = 1'b0;
            resp = 2'h3;
            @(posedge mclk);
            s_axi_awvalid <= 1'b1;
            s_axi_awaddr  <= a;
            s_axi_wvalid  <= 1'b1;
            s_axi_wdata   <= v;
            s_axi_bready  <= 1'b1;
            for (k = 0; k < 64 && !got; k = k + 1) begin
                @(posedge mclk);
                if (s_axi_awvalid && s_axi_awready)
                    s_axi_awvalid <= 1'b0;
                if (s_axi_wvalid && s_axi_wready)
                    s_axi_wvalid <= 1'b0;
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bready <= 1'b0;
                    resp = s_axi_bresp;
                    got = 1'b1;
                end
            end
            if (!got)
                tmo;
        end
    endtask
    task rd(input [3:0] a, output [31:0] v, output [1:0] resp);
        integer k;
        reg     got;
        begin
            got = 1'b0;
            @(posedge mclk);
            s_axi_arvalid <= 1'b1;
            s_axi_araddr  <= a;
            s_axi_rready  <= 1'b1;
            for (k = 0; k < 64 && !got; k = k + 1) begin
                @(posedge mclk);
                if (s_axi_arvalid && s_axi_arready)
                    s_axi_arvalid <= 1'b0;
                if (s_axi_rvalid && s_axi_rready) begin
                    s_axi_rready <= 1'b0;
                    v = s_axi_rdata;
                    resp = s_axi_rresp;
                    got = 1'b1;
                end
            end
            if (!got)
                tmo;
        end
    endtask
    task rchk(input [3:0] a, input [31:0] exp, input [1:0] er, input string what);
        begin
            rd(a, d, r);
            check(what, d, exp);
            check("response", r, er);
        end
    endtask
    // capture request carries the pair in the same write
    task cap(input integer pr);
        begin
            wr(`SQM_OFF_CFG, cfgv | 32'h8000 | (pr << 8), r);
            rd(`SQM_OFF_RESULT, d, r);
        end
    endtask
    task wait_ticks(input integer n);
        integer   k;
        reg [7:0] base;
        begin
            rd(`SQM_OFF_STATUS, d, r);
            base = d[15:8];
            for (k = 0; k < 400 && 8'(d[15:8] - base) < n; k = k + 1)
                rd(`SQM_OFF_STATUS, d, r);
            if (k == 400)
                tmo;
        end
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cfgv, gig} = 73'h0;
        gap = 4'h3;
        for (p = 0; p < 4; p = p + 1)
            lv[p] = 9'h000;
        n_fail = 0;
        comparisons = 0;
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        rchk(`SQM_OFF_PAGE, 32'h0, `SQM_RESP_OKAY, "page");
        rchk(`SQM_OFF_CFG, 32'h0, `SQM_RESP_OKAY, "cfg off page");
        wr(`SQM_OFF_CFG, 32'h0000_0001, r);
        check("ignored write", r, `SQM_RESP_OKAY);
        wr(`SQM_OFF_PAGE, {27'h0, `SQM_MON_PAGE}, r);
        rchk(`SQM_OFF_CFG, {24'h0, `SQM_RST_KP, 4'h0}, `SQM_RESP_OKAY, "cfg reset");
        rchk(`SQM_OFF_RESULT, 32'h0, `SQM_RESP_OKAY, "result reset");
        rchk(4'h2, 32'h0, `SQM_RESP_SLVERR, "unmapped read");
        wr(4'h6, 32'h0000_0001, r);
        check("unmapped write", r, `SQM_RESP_SLVERR);
        $display("test registers done");
        gig <= 1'b1;
        lv[0] <= 9'h0C8;
        cfgv = 32'h0000_00F3;
        wr(`SQM_OFF_CFG, cfgv, r);
        wait_ticks(2);
        cap(0);
        check("slow filter", {31'h0, d < 32'h10 && d != 32'h0}, 32'h1);
        rchk(`SQM_OFF_CFG, cfgv, `SQM_RESP_OKAY, "capture bit");
        $display("test slow weight done");
        for (i = 0; i < 4; i = i + 1) begin
            gig <= TG[3 - i];
            gap <= (i == 1) ? 4'h0 : 4'h3;
            for (p = 0; p < 4; p = p + 1)
                lv[p] <= TS[9 * (15 - 4 * i - p) +: 9];
            cfgv = {30'h0, TQ[3 - i], 1'b1};
            wr(`SQM_OFF_CFG, cfgv, r);
            wait_ticks(2);
            for (p = 0; p < 4; p = p + 1) begin
                cap(p);
                check("pair result", d, {16'h0, TE[16 * (15 - 4 * i - p) +: 16]});
            end
        end
        $display("test error table done");
        cfgv = 32'h0;
        wr(`SQM_OFF_CFG, cfgv, r);
        lv[0] <= 9'h000;
        repeat (200) @(posedge mclk);
        cap(0);
        check("frozen result", d, 32'h0000_1000);
        rd(`SQM_OFF_STATUS, d, r);
        check("status bits", d[1:0], 32'h0);
        $display("test disable done");
        summarize;
    end
endmodule
